// file: verilog/irq_ctrl_pkg.sv
// Constants for the cascaded dual interrupt controller
// How it works
// - Master at 020h-021h, slave at 0A0h-0A1h
// - Slave request feeds master channel two
// - Timer 0 feeds master channel zero, clock feeds slave channel zero
// - Pins 1,3-7 master; 9-15 slave
// - Request, in-service, mask registers per unit
// - Resolver raises irq; acknowledge or poll read sets in-service bit
// - Slave matches cascade code against its identity
// - Active request sets pending bit, raises irq
// - First acknowledge sets service, clears request
// - Second acknowledge returns eight-bit vector
// - Vector is base bits plus channel number
// - Automatic end clears service after second acknowledge
// - No request at acknowledge gives level seven
// - Specific and nonspecific end-of-service commands
// - Special mask shields masked bits from nonspecific
// - Fixed priority, channel zero highest after init
// - In-service blocks equal or lower priority
// - Specific rotation makes named channel lowest
// - Automatic rotation makes serviced channel lowest
// - Init word resets counter, mask, mode state
// - Even write bit three picks command word
// - Even read gives poll, in-service or request
package irq_ctrl_pkg;

  // --------------------------------------------------
  // Port indices (byte address is four times index)
  // --------------------------------------------------
  localparam logic [9:0] MASTER_EVEN_IDX = 10'h020;
  localparam logic [9:0] MASTER_ODD_IDX  = 10'h021;
  localparam logic [9:0] SLAVE_EVEN_IDX  = 10'h0a0;
  localparam logic [9:0] SLAVE_ODD_IDX   = 10'h0a1;

  // --------------------------------------------------
  // Command word fields
  // --------------------------------------------------
  localparam int INIT_FLAG_BIT   = 4;
  localparam int READ_SELECT_WORD_SEL_BIT    = 3;
  localparam int LEVEL_MODE_BIT  = 3;
  localparam int SINGLE_BIT      = 1;
  localparam int NEED_WORD4_BIT  = 0;
  localparam int AUTO_EOS_BIT    = 1;
  localparam int POLL_BIT        = 2;
  localparam int READ_EN_BIT     = 1;
  localparam int READ_SEL_BIT    = 0;
  localparam int SMM_EN_BIT      = 6;
  localparam int SMM_VAL_BIT     = 5;

  // Rotation and end-of-service codes in bits 7:5
  localparam logic [2:0] CMD_ROT_AEOS_CLR = 3'h0;
  localparam logic [2:0] CMD_EOS_NONSPEC  = 3'h1;
  localparam logic [2:0] CMD_EOS_SPEC     = 3'h3;
  localparam logic [2:0] CMD_ROT_AEOS_SET = 3'h4;
  localparam logic [2:0] CMD_ROT_NONSPEC  = 3'h5;
  localparam logic [2:0] CMD_SET_PRIO     = 3'h6;
  localparam logic [2:0] CMD_ROT_SPEC     = 3'h7;

  // --------------------------------------------------
  // Fixed values and reset values
  // --------------------------------------------------
  localparam logic [2:0] CASCADE_CH      = 3'h2;
  localparam logic [2:0] SPURIOUS_CH     = 3'h7;
  localparam logic [2:0] SLAVE_ID_RESET  = 3'h7;
  localparam logic [2:0] LOWEST_RESET    = 3'h7;
  localparam logic [4:0] VEC_BASE_RESET  = 5'h00;
  localparam logic [7:0] MASK_RESET      = 8'h00;

  typedef enum logic [1:0] {
    INIT_RUN   = 2'b00,
    INIT_WORD2 = 2'b01,
    INIT_WORD3 = 2'b10,
    INIT_WORD4 = 2'b11
  } init_state_type;

endpackage : irq_ctrl_pkg

// file: verilog/cascaded_irq_ctrl.sv
// Interrupt unit and cascaded dual controller top with APB access
`timescale 1ns/1ps
`default_nettype none

module irq_unit
  import irq_ctrl_pkg::*;
#(
  parameter bit IS_MASTER = 1'b1
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr_en,
  input  wire logic       wr_odd,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_en,
  input  wire logic       rd_odd,
  output logic      [7:0] rd_data,
  input  wire logic [7:0] request_channels,
  input  wire logic       ack_first,
  input  wire logic       ack_second,
  input  wire logic       ack_sel,
  output logic            cpu_irq_out,
  output logic            win_valid,
  output logic      [2:0] win_ch,
  output logic            vec_mine,
  output logic      [7:0] vector,
  output logic      [2:0] slave_id
);

  // --------------------------------------------------
  // Helpers
  // --------------------------------------------------
  function automatic logic [3:0] first_set(input logic [7:0] v,
                                           input logic [2:0] low);
    logic [3:0] res;
    logic [2:0] idx;
    res = 4'h0;
    for (int i = 0; i < 8; i++) begin
      idx = 3'(low + 3'(i) + 3'd1);
      if (!res[3] && v[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction : first_set

  function automatic logic [2:0] rank(input logic [2:0] ch,
                                      input logic [2:0] low);
    return 3'(ch - low - 3'd1);
  endfunction : rank

  // --------------------------------------------------
  // State
  // --------------------------------------------------
  // request, in-service and mask registers plus mode, init and acknowledge state per unit
  logic [7:0]     pending_request_reg, pending_request_next;
  logic [7:0]     in_service_reg,      in_service_next;
  logic [7:0]     channel_mask_reg,    channel_mask_next;
  logic [7:0]     req_prev_reg,        req_prev_next;
  logic [4:0]     vec_base_reg,        vec_base_next;
  logic [2:0]     slave_id_reg,        slave_id_next;
  logic [2:0]     lowest_reg,          lowest_next;
  logic           level_mode_reg,      level_mode_next;
  logic           single_reg,          single_next;
  logic           need_word4_reg,      need_word4_next;
  logic           auto_eos_reg,        auto_eos_next;
  logic           rot_aeos_reg,        rot_aeos_next;
  logic           smm_reg,             smm_next;
  logic           read_isr_reg,        read_isr_next;
  logic           poll_reg,            poll_next;
  logic [2:0]     ack_ch_reg,          ack_ch_next;
  logic           ack_live_reg,        ack_live_next;
  logic           vec_mine_reg,        vec_mine_next;
  init_state_type init_reg,            init_next;

  logic [7:0] eff_isr;
  logic [3:0] req_win;
  logic [3:0] isr_top;
  logic [7:0] req_set;
  logic [7:0] irr_clr;
  logic [7:0] isr_set;
  logic [7:0] isr_clr;
  logic [2:0] cmd;
  logic [2:0] lvl;

  // --------------------------------------------------
  // Priority resolver
  // --------------------------------------------------
  always_comb begin
    // Special mask hides masked in-service bits
    eff_isr = smm_reg ? (in_service_reg & ~channel_mask_reg)
                      : in_service_reg;
    req_win = first_set(pending_request_reg & ~channel_mask_reg,
                        lowest_reg);
    isr_top = first_set(eff_isr, lowest_reg);
    win_valid = req_win[3] &&
                (!isr_top[3] ||
                 rank(req_win[2:0], lowest_reg) <
                 rank(isr_top[2:0], lowest_reg));
    win_ch = req_win[2:0];
  end

  assign cpu_irq_out = win_valid;
  assign vec_mine    = vec_mine_reg;
  assign vector      = {vec_base_reg, ack_ch_reg};
  assign slave_id    = slave_id_reg;

  always_comb begin
    if (rd_odd) begin
      rd_data = channel_mask_reg;
    end else if (poll_reg) begin
      rd_data = {win_valid, 4'h0, win_ch};
    end else if (read_isr_reg) begin
      rd_data = in_service_reg;
    end else begin
      rd_data = pending_request_reg;
    end
  end

  // --------------------------------------------------
  // Next state
  // --------------------------------------------------
  always_comb begin
    channel_mask_next = channel_mask_reg;
    vec_base_next     = vec_base_reg;
    slave_id_next     = slave_id_reg;
    lowest_next       = lowest_reg;
    level_mode_next   = level_mode_reg;
    single_next       = single_reg;
    need_word4_next   = need_word4_reg;
    auto_eos_next     = auto_eos_reg;
    rot_aeos_next     = rot_aeos_reg;
    smm_next          = smm_reg;
    read_isr_next     = read_isr_reg;
    poll_next         = poll_reg;
    ack_ch_next       = ack_ch_reg;
    ack_live_next     = ack_live_reg;
    vec_mine_next     = vec_mine_reg;
    init_next         = init_reg;
    req_prev_next     = request_channels;
    irr_clr           = 8'h00;
    isr_set           = 8'h00;
    isr_clr           = 8'h00;
    cmd               = wr_data[7:5];
    lvl               = wr_data[2:0];

    req_set = level_mode_reg ? request_channels
                             : (request_channels & ~req_prev_reg);

    if (ack_first) begin
      if (ack_sel && win_valid) begin
        isr_set[win_ch] = 1'b1;
        irr_clr[win_ch] = 1'b1;
        ack_ch_next     = win_ch;
        ack_live_next   = 1'b1;
        vec_mine_next   = !(IS_MASTER && win_ch == CASCADE_CH);
      end else if (ack_sel) begin
        ack_ch_next     = SPURIOUS_CH;
        ack_live_next   = 1'b0;
        vec_mine_next   = 1'b1;
      end else begin
        ack_live_next   = 1'b0;
        vec_mine_next   = 1'b0;
      end
    end

    if (ack_second && auto_eos_reg && ack_live_reg) begin
      isr_clr[ack_ch_reg] = 1'b1;
      if (rot_aeos_reg) begin
        lowest_next = ack_ch_reg;
      end
    end

    // Poll read acts as an acknowledge
    if (rd_en && !rd_odd && poll_reg) begin
      poll_next = 1'b0;
      if (win_valid) begin
        isr_set[win_ch] = 1'b1;
        irr_clr[win_ch] = 1'b1;
      end
    end

    if (wr_en && !wr_odd && wr_data[INIT_FLAG_BIT]) begin
      init_next         = INIT_WORD2;
      level_mode_next   = wr_data[LEVEL_MODE_BIT];
      single_next       = wr_data[SINGLE_BIT];
      need_word4_next   = wr_data[NEED_WORD4_BIT];
      lowest_next       = LOWEST_RESET;
      rot_aeos_next     = 1'b0;
      auto_eos_next     = 1'b0;
      channel_mask_next = MASK_RESET;
      slave_id_next     = SLAVE_ID_RESET;
      smm_next          = 1'b0;
      read_isr_next     = 1'b0;
      poll_next         = 1'b0;
    end else if (wr_en && !wr_odd) begin
      init_next = INIT_RUN;
      if (!wr_data[READ_SELECT_WORD_SEL_BIT]) begin
        unique case (cmd)
          CMD_EOS_NONSPEC: begin
            if (isr_top[3]) isr_clr[isr_top[2:0]] = 1'b1;
          end
          CMD_ROT_NONSPEC: begin
            if (isr_top[3]) begin
              isr_clr[isr_top[2:0]] = 1'b1;
              lowest_next = isr_top[2:0];
            end
          end
          CMD_EOS_SPEC: isr_clr[lvl] = 1'b1;
          CMD_ROT_SPEC: begin
            isr_clr[lvl] = 1'b1;
            lowest_next  = lvl;
          end
          CMD_SET_PRIO:     lowest_next   = lvl;
          CMD_ROT_AEOS_SET: rot_aeos_next = 1'b1;
          CMD_ROT_AEOS_CLR: rot_aeos_next = 1'b0;
          default: ;
        endcase
      end else begin
        poll_next = wr_data[POLL_BIT];
        if (wr_data[READ_EN_BIT]) begin
          read_isr_next = !wr_data[READ_SEL_BIT];
        end
        if (wr_data[SMM_EN_BIT]) begin
          smm_next = wr_data[SMM_VAL_BIT];
        end
      end
    end else if (wr_en) begin
      unique case (init_reg)
        INIT_WORD2: begin
          vec_base_next = wr_data[7:3];
          init_next = single_reg ?
                      (need_word4_reg ? INIT_WORD4 : INIT_RUN) :
                      INIT_WORD3;
        end
        INIT_WORD3: begin
          slave_id_next = wr_data[2:0];
          init_next = need_word4_reg ? INIT_WORD4 : INIT_RUN;
        end
        INIT_WORD4: begin
          auto_eos_next = wr_data[AUTO_EOS_BIT];
          init_next     = INIT_RUN;
        end
        INIT_RUN: channel_mask_next = wr_data;
      endcase
    end

    // Hardware set wins over any clear
    pending_request_next = ((pending_request_reg & ~irr_clr) | req_set) &
                           (level_mode_reg ? request_channels : 8'hff);
    in_service_next = (in_service_reg & ~isr_clr) | isr_set;
  end

  // --------------------------------------------------
  // Registers
  // --------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pending_request_reg <= 8'h00;
      in_service_reg      <= 8'h00;
      channel_mask_reg    <= MASK_RESET;
      req_prev_reg        <= 8'h00;
      vec_base_reg        <= VEC_BASE_RESET;
      slave_id_reg        <= SLAVE_ID_RESET;
      lowest_reg          <= LOWEST_RESET;
      level_mode_reg      <= 1'b0;
      single_reg          <= 1'b0;
      need_word4_reg      <= 1'b0;
      auto_eos_reg        <= 1'b0;
      rot_aeos_reg        <= 1'b0;
      smm_reg             <= 1'b0;
      read_isr_reg        <= 1'b0;
      poll_reg            <= 1'b0;
      ack_ch_reg          <= SPURIOUS_CH;
      ack_live_reg        <= 1'b0;
      vec_mine_reg        <= 1'b0;
      init_reg            <= INIT_RUN;
    end else begin
      pending_request_reg <= pending_request_next;
      in_service_reg      <= in_service_next;
      channel_mask_reg    <= channel_mask_next;
      req_prev_reg        <= req_prev_next;
      vec_base_reg        <= vec_base_next;
      slave_id_reg        <= slave_id_next;
      lowest_reg          <= lowest_next;
      level_mode_reg      <= level_mode_next;
      single_reg          <= single_next;
      need_word4_reg      <= need_word4_next;
      auto_eos_reg        <= auto_eos_next;
      rot_aeos_reg        <= rot_aeos_next;
      smm_reg             <= smm_next;
      read_isr_reg        <= read_isr_next;
      poll_reg            <= poll_next;
      ack_ch_reg          <= ack_ch_next;
      ack_live_reg        <= ack_live_next;
      vec_mine_reg        <= vec_mine_next;
      init_reg            <= init_next;
    end
  end

endmodule : irq_unit

module cascaded_irq_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input  wire logic                  SYS_CLK,
  input  wire logic                  SRST,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [ADDR_WIDTH-1:0] PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire logic                  TIMER0_OUTPUT,
  input  wire logic                  RTC_IRQ,
  input  wire logic                  IRQ1_PIN,
  input  wire logic [4:0]            IRQ_LOW_PINS,
  input  wire logic [6:0]            IRQ_HIGH_PINS,
  input  wire logic                  IRQ_ACK_CYCLE,
  output logic                       CPU_IRQ_OUT,
  output logic      [7:0]            VECTOR_DATA,
  output logic                       VECTOR_VALID
);

  if (ADDR_WIDTH < 10) begin : g_addr_check
    $error("ADDR_WIDTH too small for port map");
  end

  // --------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------
  logic [14:0] pin_raw;
  logic [14:0] sync1_reg, sync1_next;
  logic [14:0] sync2_reg, sync2_next;

  assign pin_raw = {IRQ_HIGH_PINS, RTC_IRQ, IRQ_LOW_PINS, IRQ1_PIN,
                    TIMER0_OUTPUT};

  always_comb begin
    sync1_next = pin_raw;
    sync2_next = sync1_reg;
  end

  // --------------------------------------------------
  // APB decode
  // --------------------------------------------------
  logic [9:0]  idx;
  logic        aligned;
  logic        hit_m;
  logic        hit_s;
  logic        access;
  logic        setup;
  logic [7:0]  rd_m;
  logic [7:0]  rd_s;
  logic [31:0] prdata_reg, prdata_next;

  assign idx     = PADDR[11:2];
  assign aligned = (PADDR[1:0] == 2'b00) &&
                   ((PADDR >> 12) == '0);
  assign hit_m   = aligned && (idx == MASTER_EVEN_IDX ||
                               idx == MASTER_ODD_IDX);
  assign hit_s   = aligned && (idx == SLAVE_EVEN_IDX ||
                               idx == SLAVE_ODD_IDX);
  assign access  = PSEL && PENABLE;
  assign setup   = PSEL && !PENABLE;
  assign PREADY  = 1'b1;
  assign PSLVERR = access && !hit_m && !hit_s;
  assign PRDATA  = prdata_reg;

  always_comb begin
    prdata_next = prdata_reg;
    if (setup && !PWRITE) begin
      prdata_next = {24'h000000, hit_m ? rd_m : (hit_s ? rd_s : 8'h00)};
    end
  end

  // --------------------------------------------------
  // Acknowledge sequencing and vector
  // --------------------------------------------------
  logic       ack_phase_reg, ack_phase_next;
  logic [7:0] vector_reg,    vector_next;
  logic       valid_reg,     valid_next;
  logic       ack_first;
  logic       ack_second;
  logic       irq_m;
  logic       irq_s;
  logic       win_m;
  logic [2:0] ch_m;
  logic       mine_s;
  logic [7:0] vec_m;
  logic [7:0] vec_s;
  logic [2:0] id_s;
  logic       slave_sel;

  assign ack_first  = IRQ_ACK_CYCLE && !ack_phase_reg;
  assign ack_second = IRQ_ACK_CYCLE && ack_phase_reg;
  assign slave_sel  = win_m && ch_m == CASCADE_CH && id_s == CASCADE_CH;

  always_comb begin
    ack_phase_next = IRQ_ACK_CYCLE ? !ack_phase_reg : ack_phase_reg;
    vector_next    = vector_reg;
    valid_next     = ack_second;
    if (ack_second) begin
      vector_next = mine_s ? vec_s : vec_m;
    end
  end

  assign CPU_IRQ_OUT  = irq_m;
  assign VECTOR_DATA  = vector_reg;
  assign VECTOR_VALID = valid_reg;

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      sync1_reg     <= 15'h0000;
      sync2_reg     <= 15'h0000;
      prdata_reg    <= 32'h00000000;
      ack_phase_reg <= 1'b0;
      vector_reg    <= 8'h00;
      valid_reg     <= 1'b0;
    end else begin
      sync1_reg     <= sync1_next;
      sync2_reg     <= sync2_next;
      prdata_reg    <= prdata_next;
      ack_phase_reg <= ack_phase_next;
      vector_reg    <= vector_next;
      valid_reg     <= valid_next;
    end
  end

  // --------------------------------------------------
  // Units
  // --------------------------------------------------
  irq_unit #(.IS_MASTER(1'b1)) master_irq_unit (
    .clk              (SYS_CLK),
    .rst              (SRST),
    .wr_en            (access && PWRITE && hit_m),
    .wr_odd           (idx[0]),
    .wr_data          (PWDATA[7:0]),
    .rd_en            (access && !PWRITE && hit_m),
    .rd_odd           (idx[0]),
    .rd_data          (rd_m),
    .request_channels ({sync2_reg[6:2], irq_s, sync2_reg[1:0]}),
    .ack_first        (ack_first),
    .ack_second       (ack_second),
    .ack_sel          (1'b1),
    .cpu_irq_out      (irq_m),
    .win_valid        (win_m),
    .win_ch           (ch_m),
    .vec_mine         (),
    .vector           (vec_m),
    .slave_id         ()
  );

  irq_unit #(.IS_MASTER(1'b0)) slave_irq_unit (
    .clk              (SYS_CLK),
    .rst              (SRST),
    .wr_en            (access && PWRITE && hit_s),
    .wr_odd           (idx[0]),
    .wr_data          (PWDATA[7:0]),
    .rd_en            (access && !PWRITE && hit_s),
    .rd_odd           (idx[0]),
    .rd_data          (rd_s),
    .request_channels (sync2_reg[14:7]),
    .ack_first        (ack_first),
    .ack_second       (ack_second),
    .ack_sel          (slave_sel),
    .cpu_irq_out      (irq_s),
    .win_valid        (),
    .win_ch           (),
    .vec_mine         (mine_s),
    .vector           (vec_s),
    .slave_id         (id_s)
  );

endmodule : cascaded_irq_ctrl

`default_nettype wire

// file: verification/irq_ctrl_chk.sv
// Port checker for the cascaded interrupt controller
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_chk (
  input wire logic        SYS_CLK,
  input wire logic        SRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PSLVERR,
  input wire logic        IRQ_ACK_CYCLE,
  input wire logic        CPU_IRQ_OUT,
  input wire logic [7:0]  VECTOR_DATA,
  input wire logic        VECTOR_VALID
);
  logic phase_reg, phase_next, spur_reg, spur_next, mapped;
  always_comb begin
    phase_next = IRQ_ACK_CYCLE ? !phase_reg : phase_reg;
    spur_next  = (IRQ_ACK_CYCLE && !phase_reg) ? !CPU_IRQ_OUT : spur_reg;
    mapped     = PADDR == 12'h080 || PADDR == 12'h084 ||
                 PADDR == 12'h280 || PADDR == 12'h284;
  end
  always_ff @(posedge SYS_CLK) begin
    phase_reg <= SRST ? 1'b0 : phase_next;
    spur_reg  <= SRST ? 1'b0 : spur_next;
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  ack_second_a: assert property (IRQ_ACK_CYCLE && phase_reg |=> VECTOR_VALID)
    else $error("no vector after second acknowledge");
  ack_first_a: assert property (IRQ_ACK_CYCLE && !phase_reg |=> !VECTOR_VALID)
    else $error("vector after first acknowledge");
  valid_pulse_a: assert property (VECTOR_VALID |=> !VECTOR_VALID)
    else $error("vector valid longer than one cycle");
  vec_hold_a: assert property (!VECTOR_VALID |-> $stable(VECTOR_DATA))
    else $error("vector changed without valid");
  spur_vec_a: assert property (VECTOR_VALID && spur_reg |-> VECTOR_DATA[2:0] == 3'h7)
    else $error("spurious vector not level seven");
  reset_quiet_a: assert property ($past(SRST) |-> !CPU_IRQ_OUT && PRDATA == 32'h0)
    else $error("outputs active after reset");
  map_err_a: assert property (PSEL && PENABLE |-> PSLVERR == !mapped)
    else $error("port decode error flag wrong");
  unmapped_rd_a: assert property (PSEL && PENABLE && !PWRITE && !mapped
    |-> PRDATA == 32'h0)
    else $error("unmapped read returned data");
endmodule : irq_ctrl_chk
bind cascaded_irq_ctrl irq_ctrl_chk chk_u (.SYS_CLK(SYS_CLK), .SRST(SRST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PSLVERR(PSLVERR), .IRQ_ACK_CYCLE(IRQ_ACK_CYCLE),
  .CPU_IRQ_OUT(CPU_IRQ_OUT), .VECTOR_DATA(VECTOR_DATA),
  .VECTOR_VALID(VECTOR_VALID));
`default_nettype wire

// file: verification/cpu_ack_model.sv
// Processor side model issuing paired acknowledge cycles
`timescale 1ns/1ps
`default_nettype none
module cpu_ack_model (
  input  wire logic clk,
  input  wire logic irq,
  input  wire logic go,
  input  wire logic spur,
  input  wire logic slow,
  output logic      ack
);
  int n;
  initial begin
    ack = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        for (n = 0; !irq && !spur && n < 40; n++) @(posedge clk);
        ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
        repeat (slow ? 5 : 1) @(posedge clk);
        ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
      end
    end
  end
endmodule : cpu_ack_model
`default_nettype wire

// file: verification/cascaded_dual_interrupt_controller_bench.sv
// Self-checking bench for the cascaded interrupt controller
`timescale 1ns/1ps
`default_nettype none
module cascaded_dual_interrupt_controller_bench import irq_ctrl_pkg::*;;
  logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        tmr = 1'b0, rtc = 1'b0, irq1 = 1'b0, go = 1'b0, spur = 1'b0;
  logic        slow = 1'b0, ack, cpu_irq, vvalid, pready, pslverr;
  logic [4:0]  lowp = 5'h00;
  logic [6:0]  highp = 7'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0]  vec, m;
  logic [7:0]  rq[$], vq[$];
  int          err_count = 0, total_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  cascaded_irq_ctrl dut_u (.SYS_CLK(clk), .SRST(srst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TIMER0_OUTPUT(tmr), .RTC_IRQ(rtc), .IRQ1_PIN(irq1),
    .IRQ_LOW_PINS(lowp), .IRQ_HIGH_PINS(highp), .IRQ_ACK_CYCLE(ack),
    .CPU_IRQ_OUT(cpu_irq), .VECTOR_DATA(vec), .VECTOR_VALID(vvalid));
  cpu_ack_model cpu_u (.clk(clk), .irq(cpu_irq), .go(go), .spur(spur),
    .slow(slow), .ack(ack));
  task automatic report_and_stop;
    $display("Checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input string nm, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : bus
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    rq.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rd
  task automatic init(input logic [11:0] a, input logic [7:0] b, c, d);
    bus(1'b1, a, 8'h11);
    bus(1'b1, a + 12'h4, b);
    bus(1'b1, a + 12'h4, c);
    bus(1'b1, a + 12'h4, d);
  endtask : init
  task automatic pulse(input logic [15:0] p);
    {highp, rtc, lowp, irq1, tmr} <= {p[15:8], p[7:3], p[1:0]};
    repeat (4) @(posedge clk);
    {highp, rtc, lowp, irq1, tmr} <= 15'h0;
    repeat (4) @(posedge clk);
  endtask : pulse
  task automatic acks(input logic s, input logic [7:0] e);
    vq.push_back(e);
    spur <= s;
    slow <= 1'($urandom);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    while (vq.size() != 0) @(posedge clk);
  endtask : acks
  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(posedge clk) begin
    if (psel && pen && !pwr && pready)
      check("read", prdata[7:0], rq.pop_front());
    if (vvalid === 1'b1)
      check("vector", vec, vq.pop_front());
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h1b6a));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(12'h084, 8'h00);
    rd(12'h280, 8'h00);
    bus(1'b1, 12'h100, 8'hff);
    rd(12'h100, 8'h00);
    bus(1'b1, 12'h084, 8'hff);
    init(12'h080, 8'h08, 8'h04, 8'h00);
    init(12'h280, 8'h70, 8'h02, 8'h00);
    rd(12'h084, 8'h00);
    m = 8'($urandom);
    bus(1'b1, 12'h284, m);
    rd(12'h284, m);
    bus(1'b1, 12'h284, 8'h00);
    pulse(16'h0009);
    acks(1'b0, 8'h08);
    acks(1'b1, 8'h0f);
    bus(1'b1, 12'h080, 8'h20);
    acks(1'b0, 8'h0b);
    bus(1'b1, 12'h080, 8'h20);
    pulse(16'h8100);
    acks(1'b0, 8'h70);
    bus(1'b1, 12'h280, 8'h20);
    bus(1'b1, 12'h080, 8'h20);
    acks(1'b0, 8'h77);
    bus(1'b1, 12'h280, 8'h20);
    bus(1'b1, 12'h080, 8'h20);
    bus(1'b1, 12'h080, 8'hc5);
    pulse(16'h0042);
    acks(1'b0, 8'h0e);
    bus(1'b1, 12'h080, 8'h66);
    acks(1'b0, 8'h09);
    bus(1'b1, 12'h080, 8'h61);
    bus(1'b1, 12'h080, 8'hc7);
    init(12'h080, 8'h08, 8'h04, 8'h02);
    pulse(16'h0010);
    acks(1'b0, 8'h0c);
    bus(1'b1, 12'h080, 8'h0a);
    rd(12'h080, 8'h00);
    pulse(16'h0020);
    bus(1'b1, 12'h080, 8'h0c);
    rd(12'h080, 8'h85);
    rd(12'h080, 8'h20);
    bus(1'b1, 12'h080, 8'h20);
    rd(12'h080, 8'h00);
    report_and_stop();
  end
endmodule : cascaded_dual_interrupt_controller_bench
`default_nettype wire
